// ### src/tuner_bus_master.v
// Serial bus master that writes, reads and fetches fuse columns of the tuner
// Function
// R1: Fuse read writes column to ROM index field, then reads readback register.
// R2: Reading fuse columns other than zero may disturb the tuner bias current.
// R3: Bus clock never exceeds 400 kHz; the master supplies it.
// R4: Only the master starts transfers and drives the serial clock.
// R5: One bit per SCL cycle; nine cycles per byte including acknowledge.
// R6: SDA moves only while SCL is low, except for START and STOP.
// R7: Both lines are released while no transfer runs.
// R8: START is SDA falling while SCL is high.
// R9: STOP is SDA rising while SCL is high.
// R10: Acknowledge holds SDA low across the ninth clock's high phase.
// R11: Not-acknowledge leaves SDA high across the ninth clock's high phase.
// R12: A missing acknowledge fails the transfer; the master retries later. The master retries only an address NACK, at most 3 times.
// R13: Slave address byte is 11000, select pin level, 0, then direction.
// R14: The bit after the seven address bits is 0 for write, 1 for read.
// R15: Slave acknowledges its own address after START, then follows direction.
// R16: A write sends the starting register index after the address byte.
// R17: Data goes MSB first; each byte lands in the next register.
// R18: A write stays open for more bytes until STOP.
// R19: A read first writes the index, then repeated START with read address.
// R20: Slave shifts read data MSB first from the selected index.
// R21: Master acknowledge continues reading; not-acknowledge ends data, STOP closes.
// R22: A slave whose address does not match stays silent until next START.
`include "tuner_bus_consts.vh"

module tuner_bus_master #(
	parameter RETRY_GAP_CYC = `RETRY_GAP_CYC
) (
	input  wire       i_clk_sys,
	input  wire       i_rst_n,
	input  wire       i_go,
	input  wire [1:0] i_op,
	input  wire [7:0] i_reg_index,
	input  wire [7:0] i_count,
	input  wire       i_slave_addr_select_pin,
	input  wire [7:0] i_wr_data,
	input  wire       i_wr_valid,
	output wire       o_wr_ready,
	output reg  [7:0] o_rd_data,
	output reg        o_rd_valid,
	output reg        o_busy,
	output reg        o_done,
	output reg        o_error,
	input  wire       i_scl,
	output wire       o_scl,
	output wire       o_scl_oe_n,
	input  wire       i_sda,
	output wire       o_sda,
	output wire       o_sda_oe_n
);

	// ==========================================================
	// States and stages
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_START = 3'h1;
	localparam [2:0] ST_TX    = 3'h2;
	localparam [2:0] ST_RX    = 3'h3;
	localparam [2:0] ST_STOP  = 3'h4;
	localparam [2:0] ST_WLOAD = 3'h5;
	localparam [2:0] ST_WAIT  = 3'h6;

	localparam [2:0] SG_ADDR_W = 3'h0;
	localparam [2:0] SG_INDEX  = 3'h1;
	localparam [2:0] SG_WDATA  = 3'h2;
	localparam [2:0] SG_COLUMN = 3'h3;
	localparam [2:0] SG_ADDR_R = 3'h4;
	localparam [2:0] SG_RDATA  = 3'h5;

	localparam integer GAP_CYC  = RETRY_GAP_CYC;
	localparam [12:0]  GAP_LAST = GAP_CYC[12:0] - 13'h0001;

	reg  [2:0]  state;
	reg  [2:0]  stage;
	reg  [1:0]  op;
	reg         pass2;
	reg         sel;
	reg  [7:0]  index;
	reg  [7:0]  count;
	reg  [7:0]  shreg;
	reg  [3:0]  bitn;
	reg         pend;
	reg         cmd_valid;
	reg  [1:0]  cmd;
	reg         cmd_bit;
	reg         retry;
	reg  [1:0]  tries;
	reg  [12:0] gap;
	wire        eng_done;
	wire        eng_rx;
	wire        last_rd;

	// Address byte for the chosen strap level and direction
	function [7:0] addr_byte;
		input s;
		input rw;
		begin
			addr_byte = {`ADDR_HIGH5, s, 1'b0, rw}; // see R13 R14
		end
	endfunction

	assign o_wr_ready = (state == ST_WLOAD);
	assign last_rd    = (count <= 8'h01);

	// ==========================================================
	// Bit engine
	bus_bit_engine u_engine (
		.i_clk_sys   (i_clk_sys),
		.i_rst_n     (i_rst_n),
		.i_cmd_valid (cmd_valid),
		.i_cmd       (cmd),
		.i_bit       (cmd_bit),
		.i_scl       (i_scl),
		.i_sda       (i_sda),
		.o_done      (eng_done),
		.o_rx_bit    (eng_rx),
		.o_scl       (o_scl),
		.o_scl_oe_n  (o_scl_oe_n),
		.o_sda       (o_sda),
		.o_sda_oe_n  (o_sda_oe_n)
	);

	// ==========================================================
	// Byte and transaction sequencer
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state      <= ST_IDLE;
			stage      <= SG_ADDR_W;
			op         <= `OP_WRITE;
			pass2      <= 1'b0;
			sel        <= 1'b0;
			index      <= 8'h00;
			count      <= 8'h00;
			shreg      <= 8'h00;
			bitn       <= 4'h0;
			pend       <= 1'b0;
			cmd_valid  <= 1'b0;
			cmd        <= `BIT_STOP;
			cmd_bit    <= 1'b1;
			retry      <= 1'b0;
			tries      <= 2'h0;
			gap        <= 13'h0000;
			o_rd_data  <= 8'h00;
			o_rd_valid <= 1'b0;
			o_busy     <= 1'b0;
			o_done     <= 1'b0;
			o_error    <= 1'b0;
		end else begin
			cmd_valid  <= 1'b0;
			o_rd_valid <= 1'b0;
			o_done     <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (i_go) begin // see R4
						op      <= i_op;
						index   <= i_reg_index;
						sel     <= i_slave_addr_select_pin;
						count   <= (i_op == `OP_FUSE || (i_op == `OP_READ && i_count == 8'h00)) ? 8'h01 : i_count;
						pass2   <= 1'b0;
						stage   <= SG_ADDR_W;
						tries   <= 2'h0;
						retry   <= 1'b0;
						o_error <= 1'b0;
						o_busy  <= 1'b1;
						state   <= ST_START;
					end
				end
				ST_START: begin
					if (!pend) begin
						cmd_valid <= 1'b1;
						pend      <= 1'b1;
						cmd       <= `BIT_START; // see R8 R19
					end else if (eng_done) begin
						pend  <= 1'b0;
						shreg <= addr_byte(sel, stage == SG_ADDR_R); // see R19
						bitn  <= 4'h0;
						state <= ST_TX;
					end
				end
				ST_TX: begin
					if (!pend) begin
						cmd_valid <= 1'b1;
						pend      <= 1'b1;
						cmd       <= (bitn == 4'h8) ? `BIT_READ : `BIT_WRITE;
						cmd_bit   <= shreg[7]; // see R17
					end else if (eng_done) begin
						pend <= 1'b0;
						if (bitn != 4'h8) begin
							shreg <= {shreg[6:0], 1'b0};
							bitn  <= bitn + 4'h1;
						end else if (eng_rx) begin
							state <= ST_STOP; // see R12
							if ((stage == SG_ADDR_W || stage == SG_ADDR_R) && tries != `RETRY_MAX) begin
								retry <= 1'b1;
								tries <= tries + 2'h1;
							end else begin
								o_error <= 1'b1;
							end
						end else begin
							bitn <= 4'h0;
							case (stage)
								SG_ADDR_W: begin
									stage <= SG_INDEX; // see R16
									if (op == `OP_FUSE) begin
										shreg <= pass2 ? `FILTER_ROM_READBACK_REG : `FILTER_ROM_INDEX_FIELD; // see R1
									end else begin
										shreg <= index;
									end
								end
								SG_INDEX: begin
									if (op == `OP_WRITE) begin
										state <= (count == 8'h00) ? ST_STOP : ST_WLOAD;
									end else if (op == `OP_FUSE && !pass2) begin
										stage <= SG_COLUMN; // see R1
										shreg <= index;
									end else begin
										stage <= SG_ADDR_R; // see R19
										state <= ST_START;
									end
								end
								SG_WDATA: begin
									count <= count - 8'h01;
									state <= (count == 8'h01) ? ST_STOP : ST_WLOAD; // see R18
								end
								SG_ADDR_R: begin
									stage <= SG_RDATA; // see R20
									state <= ST_RX;
								end
								default: begin
									state <= ST_STOP;
								end
							endcase
						end
					end
				end
				ST_WLOAD: begin
					if (i_wr_valid) begin
						shreg <= i_wr_data;
						bitn  <= 4'h0;
						stage <= SG_WDATA;
						state <= ST_TX;
					end
				end
				ST_RX: begin
					if (!pend) begin
						cmd_valid <= 1'b1;
						pend      <= 1'b1;
						cmd       <= (bitn == 4'h8) ? `BIT_WRITE : `BIT_READ;
						cmd_bit   <= last_rd; // see R10 R11 R21
					end else if (eng_done) begin
						pend <= 1'b0;
						if (bitn != 4'h8) begin
							shreg <= {shreg[6:0], eng_rx}; // see R20
							bitn  <= bitn + 4'h1;
							if (bitn == 4'h7) begin
								o_rd_data  <= {shreg[6:0], eng_rx};
								o_rd_valid <= 1'b1;
							end
						end else if (last_rd) begin
							state <= ST_STOP; // see R21
						end else begin
							count <= count - 8'h01;
							bitn  <= 4'h0;
						end
					end
				end
				ST_STOP: begin
					if (!pend) begin
						cmd_valid <= 1'b1;
						pend      <= 1'b1;
						cmd       <= `BIT_STOP; // see R9 R7
					end else if (eng_done) begin
						pend <= 1'b0;
						if (retry) begin
							retry <= 1'b0;
							gap   <= 13'h0000;
							state <= ST_WAIT;
						end else if (op == `OP_FUSE && !pass2 && !o_error) begin
							pass2 <= 1'b1;
							stage <= SG_ADDR_W;
							state <= ST_START;
						end else begin
							o_busy <= 1'b0;
							o_done <= 1'b1;
							state  <= ST_IDLE;
						end
					end
				end
				ST_WAIT: begin
					if (gap == GAP_LAST) begin
						stage <= SG_ADDR_W; // see R12
						state <= ST_START;
					end else begin
						gap <= gap + 13'h0001;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// ### src/tuner_bus_consts.vh
// Constants shared by the tuner serial bus master and its bit engine
`ifndef TUNER_BUS_CONSTS_VH
`define TUNER_BUS_CONSTS_VH

// ==========================================================
// Timing
`define CLK_PERIOD_NS    20
`define SCL_PERIOD_NS    2500
`define SCL_QUARTER_CYC  ((`SCL_PERIOD_NS + 4 * `CLK_PERIOD_NS - 1) / (4 * `CLK_PERIOD_NS))
`define RETRY_GAP_US     100
`define RETRY_GAP_CYC    (`RETRY_GAP_US * 1000 / `CLK_PERIOD_NS)
`define RETRY_MAX        2'h3

// ==========================================================
// Bit engine commands
`define BIT_START        2'h0
`define BIT_STOP         2'h1
`define BIT_WRITE        2'h2
`define BIT_READ         2'h3

// ==========================================================
// Transaction kinds
`define OP_WRITE         2'h0
`define OP_READ          2'h1
`define OP_FUSE          2'h2

// ==========================================================
// Slave address and register indices
`define ADDR_HIGH5       5'h18
`define FILTER_ROM_INDEX_FIELD  8'h0d
`define FILTER_ROM_READBACK_REG 8'h10

`endif

// ### src/bus_bit_engine.v
// Bit level engine: START, STOP, one written bit or one read bit on SCL/SDA
`include "tuner_bus_consts.vh"

module bus_bit_engine (
	input  wire       i_clk_sys,
	input  wire       i_rst_n,
	input  wire       i_cmd_valid,
	input  wire [1:0] i_cmd,
	input  wire       i_bit,
	input  wire       i_scl,
	input  wire       i_sda,
	output reg        o_done,
	output reg        o_rx_bit,
	output wire       o_scl,
	output reg        o_scl_oe_n,
	output wire       o_sda,
	output reg        o_sda_oe_n
);

	localparam integer QUARTER_CYC  = `SCL_QUARTER_CYC; // see R3
	localparam [5:0]   QUARTER_LAST = QUARTER_CYC[5:0] - 6'h01;

	reg       scl_meta;
	reg       scl_s;
	reg       sda_meta;
	reg       sda_s;
	reg       run;
	reg [1:0] cmd;
	reg       tx_bit;
	reg [1:0] phase;
	reg [5:0] tick;
	wire [1:0] pull;

	// Returns {sda_low, scl_low} for a command in a quarter of the bit
	function [1:0] pull_low;
		input [1:0] c;
		input [1:0] ph;
		input       b;
		reg         scl_lo;
		begin
			scl_lo = (ph == 2'h0) || (ph == 2'h3);
			case (c)
				`BIT_START: pull_low = {ph[1], scl_lo};             // see R8
				`BIT_STOP:  pull_low = {ph != 2'h3, ph == 2'h0};    // see R9
				`BIT_WRITE: pull_low = {~b, scl_lo};                // see R6
				default:    pull_low = {1'b0, scl_lo};
			endcase
		end
	endfunction

	assign pull = pull_low(cmd, phase, tx_bit);
	assign o_scl = 1'b0;
	assign o_sda = 1'b0;

	// ==========================================================
	// Input synchronisers
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_meta <= 1'b1;
			scl_s    <= 1'b1;
			sda_meta <= 1'b1;
			sda_s    <= 1'b1;
		end else begin
			scl_meta <= i_scl;
			scl_s    <= scl_meta;
			sda_meta <= i_sda;
			sda_s    <= sda_meta;
		end
	end

	// ==========================================================
	// Quarter sequencer
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run        <= 1'b0;
			cmd        <= `BIT_STOP;
			tx_bit     <= 1'b1;
			phase      <= 2'h0;
			tick       <= 6'h00;
			o_done     <= 1'b0;
			o_rx_bit   <= 1'b1;
			o_scl_oe_n <= 1'b1;
			o_sda_oe_n <= 1'b1;
		end else begin
			o_done <= 1'b0;
			if (!run) begin
				if (i_cmd_valid) begin
					run    <= 1'b1;
					cmd    <= i_cmd;
					tx_bit <= i_bit;
					phase  <= 2'h0;
					tick   <= 6'h00;
				end
			end else begin
				o_sda_oe_n <= ~pull[1];
				o_scl_oe_n <= ~pull[0];
				if (tick != QUARTER_LAST) begin
					tick <= tick + 6'h01;
				end else if (phase == 2'h1 && !scl_s) begin
					tick <= tick;
				end else begin
					tick  <= 6'h00;
					phase <= phase + 2'h1;
					if (phase == 2'h2) begin
						o_rx_bit <= sda_s; // see R10 R11
					end
					if (phase == 2'h3) begin
						run    <= 1'b0;
						o_done <= 1'b1; // see R5
					end
				end
			end
		end
	end

endmodule

// ### test/tuner_bus_master_asserts.sv
// Port checks for the tuner serial bus master
module tuner_bus_master_asserts (
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_go,
	input wire i_wr_valid,
	input wire o_wr_ready,
	input wire o_rd_valid,
	input wire o_busy,
	input wire o_done,
	input wire o_error,
	input wire o_scl_oe_n,
	input wire o_sda_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	reg [7:0] scl_gap;
	reg       scl_prev;
	// ==========================================================
	// Cycles since the last SCL release
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_gap  <= 8'hff;
			scl_prev <= 1'b1;
		end else begin
			scl_prev <= o_scl_oe_n;
			if (o_scl_oe_n && !scl_prev)
				scl_gap <= 8'h00;
			else if (scl_gap != 8'hff)
				scl_gap <= scl_gap + 8'h01;
		end
	end
	// ==========================================================
	// Properties
	property p_idle; !o_busy |-> o_scl_oe_n && o_sda_oe_n; endproperty
	property p_go; i_go && !o_busy |=> o_busy; endproperty
	property p_done; o_done |-> !o_busy ##1 !o_done; endproperty
	property p_scl_high; $rose(o_scl_oe_n) |-> o_scl_oe_n [*8]; endproperty
	property p_scl_rate; $rose(o_scl_oe_n) |-> scl_gap >= 8'h7c; endproperty
	property p_rd; o_rd_valid |-> o_busy ##1 !o_rd_valid; endproperty
	property p_wr_low; o_wr_ready |-> !o_scl_oe_n; endproperty
	property p_wr_take; o_wr_ready && i_wr_valid |=> !o_wr_ready; endproperty
	property p_err; o_error && !i_go |=> o_error; endproperty
	a_idle: assert property (p_idle) else $error("lines not released when idle");
	a_go: assert property (p_go) else $error("busy missing after go");
	a_done: assert property (p_done) else $error("done not a clean pulse");
	a_scl_high: assert property (p_scl_high) else $error("scl high phase short");
	a_scl_rate: assert property (p_scl_rate) else $error("scl faster than allowed");
	a_rd: assert property (p_rd) else $error("read valid outside transfer");
	a_wr_low: assert property (p_wr_low) else $error("scl released while waiting");
	a_wr_take: assert property (p_wr_take) else $error("write ready stuck");
	a_err: assert property (p_err) else $error("error flag dropped");
	c_rd: cover property (o_rd_valid);
	c_err: cover property ($rose(o_error));
	c_wr: cover property (o_wr_ready && i_wr_valid);
endmodule

bind tuner_bus_master tuner_bus_master_asserts chk_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_go(i_go),
	.i_wr_valid(i_wr_valid), .o_wr_ready(o_wr_ready), .o_rd_valid(o_rd_valid), .o_busy(o_busy), .o_done(o_done),
	.o_error(o_error), .o_scl_oe_n(o_scl_oe_n), .o_sda_oe_n(o_sda_oe_n));

// ### test/tuner_slave_model.sv
// Behavioural tuner serial slave with a byte register file
module tuner_slave_model (
	input  wire i_scl,
	input  wire i_sda,
	input  wire i_sel,
	output reg  o_sda_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [7:0] mem [0:255];
	reg [7:0] sh, ptr;
	reg [1:0] st;
	reg       act, rd, bias_upset;
	integer   bc;
	initial begin
		o_sda_oe_n = 1'b1;
		act        = 1'b0;
		bias_upset = 1'b0;
	end
	// ==========================================================
	// Framing
	always @(negedge i_sda) if (i_scl === 1'b1) begin
		act = 1'b1;
		rd  = 1'b0;
		st  = 2'h0;
		bc  = -1;
	end
	always @(posedge i_sda) if (i_scl === 1'b1) begin
		act        = 1'b0;
		o_sda_oe_n = 1'b1;
	end
	// ==========================================================
	// Bits
	always @(posedge i_scl) if (act) begin
		if (bc < 8 && !rd)
			sh = {sh[6:0], i_sda};
		else if (bc == 8 && rd && i_sda)
			act = 1'b0;
	end
	always @(negedge i_scl) if (act) begin
		bc         = (bc == 8) ? 0 : bc + 1;
		o_sda_oe_n = 1'b1;
		if (bc == 8 && !rd) begin
			if (st == 2'h0) begin
				if (sh[7:1] == {5'h18, i_sel, 1'b0}) begin
					rd         = sh[0];
					o_sda_oe_n = 1'b0;
				end else
					act = 1'b0;
			end else if (st == 2'h1) begin
				ptr        = sh;
				o_sda_oe_n = 1'b0;
			end else begin
				mem[ptr]   = sh;
				ptr        = ptr + 8'h01;
				o_sda_oe_n = 1'b0;
			end
			st = (st == 2'h0) ? 2'h1 : 2'h2;
		end else if (rd && bc < 8) begin
			if (bc == 0) begin
				bias_upset = bias_upset | (ptr == 8'h10 && mem[8'h0d] != 8'h00);
				sh         = (ptr == 8'h10) ? {mem[8'h0d][3:0], ~mem[8'h0d][3:0]} ^ 8'h3c : mem[ptr];
				ptr        = ptr + 8'h01;
			end
			o_sda_oe_n = sh[7 - bc];
		end
	end
endmodule

// ### test/tuner_bus_master_tb_top.sv
// Self-checking bench for the tuner serial bus master
module tuner_bus_master_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       i_clk_sys, i_rst_n, i_go, i_slave_addr_select_pin, i_wr_valid, model_sel;
	logic [1:0] i_op;
	logic [7:0] i_reg_index, i_count, i_wr_data, idx, cnt;
	wire        o_wr_ready, o_rd_valid, o_busy, o_done, o_error, o_scl_oe_n, o_sda_oe_n, model_oe_n, o_scl, o_sda;
	wire  [7:0] o_rd_data;
	wire        scl = o_scl_oe_n | o_scl;
	wire        sda = (o_sda_oe_n | o_sda) & model_oe_n;
	logic [7:0] wbuf [0:7];
	logic [7:0] rbuf [0:7];
	logic [7:0] expm [0:255];
	logic [2:0] widx, ridx;
	integer     seed, miscompares, check_count, cycles, k, j, n;

	tuner_bus_master #(.RETRY_GAP_CYC(20)) dut_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_go(i_go),
		.i_op(i_op), .i_reg_index(i_reg_index), .i_count(i_count), .i_slave_addr_select_pin(i_slave_addr_select_pin),
		.i_wr_data(i_wr_data), .i_wr_valid(i_wr_valid), .o_wr_ready(o_wr_ready), .o_rd_data(o_rd_data),
		.o_rd_valid(o_rd_valid), .o_busy(o_busy), .o_done(o_done), .o_error(o_error), .i_scl(scl), .o_scl(o_scl),
		.o_scl_oe_n(o_scl_oe_n), .i_sda(sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n));
	tuner_slave_model model_u (.i_scl(scl), .i_sda(sda), .i_sel(model_sel), .o_sda_oe_n(model_oe_n));

	function automatic [7:0] fuse_of(input [7:0] col);
		fuse_of = {col[3:0], ~col[3:0]} ^ 8'h3c;
	endfunction
	task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		check_count = check_count + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task run(input [1:0] op, input [7:0] ix, input [7:0] ct, input s);
		i_op                    <= op;
		i_reg_index             <= ix;
		i_count                 <= ct;
		i_slave_addr_select_pin <= s;
		widx                    <= 3'h0;
		ridx                    <= 3'h0;
		i_wr_data               <= wbuf[0];
		i_go                    <= 1'b1;
		@(posedge i_clk_sys);
		i_go <= 1'b0;
		while (o_done !== 1'b1) @(posedge i_clk_sys);
		@(posedge i_clk_sys);
	endtask
	task finish_test;
		if (miscompares == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Clock, watchdog, data feed and capture
	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) begin
		cycles = cycles + 1;
		// Write data offered two cycles in four, so the master must stall
		i_wr_valid <= cycles[1];
		if (cycles == 90000) begin
			miscompares = miscompares + 1;
			finish_test;
		end
		if (o_wr_ready === 1'b1 && i_wr_valid) begin
			widx      <= widx + 3'h1;
			i_wr_data <= wbuf[widx + 3'h1];
		end
		if (o_rd_valid === 1'b1) begin
			rbuf[ridx] <= o_rd_data;
			ridx       <= ridx + 3'h1;
		end
	end

	// ==========================================================
	// Scenarios
	initial begin
		seed = 43;
		miscompares = 0;
		check_count = 0;
		cycles = 0;
		{i_rst_n, i_go, i_slave_addr_select_pin, i_wr_valid, model_sel} = 5'h00;
		{i_op, i_reg_index, i_count, i_wr_data, widx, ridx} = 32'h0;
		repeat (16) @(posedge i_clk_sys);
		chk("scl_oe_n", 8'h01, {7'h00, o_scl_oe_n});
		chk("sda_oe_n", 8'h01, {7'h00, o_sda_oe_n});
		i_rst_n    <= 1'b1;
		for (k = 0; k < 3; k = k + 1) begin
			j = $random(seed);
			idx = (k == 0) ? 8'hfe : 8'h20 + {1'b0, j[6:0]};
			cnt = (j[9:8] == 2'h0) ? 8'h03 : {6'h00, j[9:8]};
			for (n = 0; n < 8; n = n + 1) begin
				j = $random(seed);
				wbuf[n] = j[7:0];
				if (n < cnt) expm[idx + n[7:0]] = wbuf[n];
			end
			model_sel <= k[0];
			run(2'h0, idx, cnt, k[0]);
			chk("wr_error", 8'h00, {7'h00, o_error});
			run(2'h1, idx, cnt, k[0]);
			for (n = 0; n < cnt; n = n + 1)
				chk("rd_data", expm[idx + n[7:0]], rbuf[n]);
			chk("rd_count", cnt, {5'h00, ridx});
		end
		run(2'h0, idx, 8'h00, 1'b0);
		chk("idx_only_error", 8'h00, {7'h00, o_error});
		run(2'h1, idx, 8'h00, 1'b0);
		chk("rd_zero_count", 8'h01, {5'h00, ridx});
		chk("rd_zero_data", expm[idx], rbuf[0]);
		model_sel <= 1'b1;
		for (k = 0; k < 2; k = k + 1) begin
			idx = (k == 0) ? 8'h00 : 8'h05;
			run(2'h2, idx, 8'h01, 1'b1);
			chk("fuse", fuse_of(idx), rbuf[0]);
			chk("bias_upset", {7'h00, idx != 8'h00}, {7'h00, model_u.bias_upset});
		end
		model_sel <= 1'b0;
		run(2'h1, 8'h30, 8'h01, 1'b1);
		chk("nack_error", 8'h01, {7'h00, o_error});
		chk("nack_rd", 8'h00, {5'h00, ridx});
		chk("idle_busy", 8'h00, {7'h00, o_busy});
		chk("idle_sda", 8'h01, {7'h00, o_sda_oe_n});
		chk("pin_drive", 8'h00, {6'h00, o_scl, o_sda});
		finish_test;
	end
endmodule
